// file: design/sdbp_regs.vh
// register offsets, field positions and reset values of the sdram register burst port
`ifndef SDBP_REGS_VH
`define SDBP_REGS_VH

// byte offsets on the local register port
`define SDBP_OFS_OP_CONTROL   16'h805c
`define SDBP_OFS_ADDR_COMMAND 16'h8060
`define SDBP_OFS_READ_BEAT0   16'h8064
`define SDBP_OFS_READ_BEAT1   16'h8068
`define SDBP_OFS_READ_BEAT2   16'h806c
`define SDBP_OFS_READ_BEAT3   16'h8070
`define SDBP_OFS_WRITE_BEAT0  16'h8074
`define SDBP_OFS_WRITE_BEAT1  16'h8078
`define SDBP_OFS_WRITE_BEAT2  16'h807c
`define SDBP_OFS_WRITE_BEAT3  16'h8080
`define SDBP_OFS_BYTE_MASK    16'h8084

// control register fields
`define SDBP_CTL_START_WRITE      0
`define SDBP_CTL_START_READ       1
`define SDBP_CTL_WRITE_FIFO_NF    26
`define SDBP_CTL_COMMAND_FIFO_NF  27

// address/command register fields
`define SDBP_AC_COL_LSB   0
`define SDBP_AC_COL_MSB   9
`define SDBP_AC_ROW_LSB   10
`define SDBP_AC_ROW_MSB   22
`define SDBP_AC_BANK_LOW  23
`define SDBP_AC_BANK_HIGH 24
`define SDBP_AC_CMD_LSB   29
`define SDBP_AC_CMD_MSB   31
`define SDBP_AC_USED_MASK 32'he1ffffff

// command codes
`define SDBP_CMD_WRITE 3'h0
`define SDBP_CMD_READ  3'h1

// mask register: one bit per byte of the four-beat burst
`define SDBP_MASK_USED 32'h0000ffff

// burst shape and reset values
`define SDBP_BURST_BEATS 4
`define SDBP_RST_WORD    32'h00000000

`endif

// file: design/sdbp_beat_mem.v
// small word memory holding the beats returned by the last burst read
`timescale 1ns/1ps
module sdbp_beat_mem #(
    parameter W  = 32,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire          i_clk,    // register clock
    input  wire          i_wen,    // write one word
    input  wire [AW-1:0] i_waddr,  // write index
    input  wire [W-1:0]  i_wdata,  // write word
    input  wire [AW-1:0] i_raddr,  // read index
    output reg  [W-1:0]  o_rdata   // read word, one cycle after i_raddr
);
    reg [W-1:0] mem [0:D-1];

    // contents persist until replaced by the next burst read
    always @(posedge i_clk)
    begin
        if (i_wen)
        begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// file: design/sdbp_port.v
// register front end launching four-beat bursts into a ddr2 memory controller
`timescale 1ns/1ps
`include "sdbp_regs.vh"

// Summary of operation
// (RL1) writing one to control bit 0 launches a four-beat burst write; zero does nothing
// (RL2) writing one to control bit 1 launches a burst read filling read registers; the code launches only the write when bit 0 is written one too
// (RL3) control bit 26 reads one while the write-data fifo is nearly full
// (RL4) control bit 27 reads one while the command fifo is nearly full
// (RL5) unused bits of control, address/command and mask registers read zero
// (RL6) address/command bits 9..0 hold the starting column
// (RL7) address/command bits 22..10 hold the row
// (RL8) address/command bits 24 and 23 drive bank select high and low
// (RL9) command field 000 in bits 31..29 is a burst write
// (RL10) command field 001 in bits 31..29 is a burst read
// (RL11) software never writes command codes 010 through 111
// (RL12) software programs address/command before setting a start bit
// (RL13) software loads write data and mask before setting the write start bit
// (RL14) read registers keep the last burst's four words until the next read
// (RL15) every access is a fixed burst of four 32-bit beats
// (RL16) software waits about 500 ns after a read start before fetching data
// (RL17) read registers answer 32, 16 or 8-bit host reads
// (RL18) four write registers supply beats zero to three in order
// (RL19) mask bit zero stores the byte, one leaves the memory byte unchanged
// (RL20) mask bit 4k+j governs byte j of write beat k
// (RL21) a mask of zero writes all sixteen bytes
// (RL22) start bits push one command each and clear once it is accepted
module sdbp_port #(
    parameter DW = 32,
    parameter AW = 16
) (
    input  wire          i_clk,                      // register clock, 200 MHz
    input  wire          i_rst_n,                    // synchronous reset, active low
    input  wire [AW-1:0] i_reg_addr,                 // register byte address
    input  wire          i_reg_wr,                   // register write strobe
    input  wire          i_reg_rd,                   // register read strobe
    input  wire [3:0]    i_reg_be,                   // byte enables
    input  wire [DW-1:0] i_reg_wdata,                // register write data
    output reg  [DW-1:0] o_reg_rdata,                // register read data
    output reg           o_reg_rd_ack,               // read data valid pulse
    output reg           o_cmd_valid,                // command fifo push request
    input  wire          i_cmd_ready,                // command fifo accepts
    output reg  [2:0]    o_cmd_code,                 // command code
    output reg           o_bank_select_high,         // bank select high
    output reg           o_bank_select_low,          // bank select low
    output reg  [12:0]   o_cmd_row,                  // row address
    output reg  [9:0]    o_cmd_col,                  // starting column
    output reg           o_wdf_valid,                // write-data fifo push request
    input  wire          i_wdf_ready,                // write-data fifo accepts
    output reg  [DW-1:0] o_wdf_data,                 // write beat data
    output reg  [3:0]    o_byte_write_suppress,      // per byte, one keeps memory byte
    input  wire          i_rd_data_valid,            // returned read beat valid
    input  wire [DW-1:0] i_rd_data,                  // returned read beat
    input  wire          i_write_fifo_nearly_full,   // controller write-data fifo level
    input  wire          i_command_fifo_nearly_full  // controller command fifo level
);
    localparam BEATS = `SDBP_BURST_BEATS;
    localparam [31:0] LAST_BEAT = BEATS - 1;

    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_WDATA = 4'h2;
    localparam [3:0] ST_CMD   = 4'h4;
    localparam [3:0] ST_RWAIT = 4'h8;

    reg  [3:0]    state_q;
    reg  [3:0]    state_d;
    reg  [DW-1:0] addr_cmd_q;
    reg  [DW-1:0] mask_q;
    reg  [DW-1:0] wbeat_q [0:BEATS-1];
    reg           start_wr_q;
    reg           start_rd_q;
    reg  [1:0]    beat_q;
    reg           rd_pend_q;
    reg  [3:0]    rd_sel_q;
    reg  [DW-1:0] rd_word_q;
    wire [DW-1:0] mem_rdata;
    wire [3:0]    wr_sel;
    wire [3:0]    rd_sel;
    wire          launch_wr;
    wire          launch_rd;
    wire          cmd_taken;
    wire          wdf_taken;
    wire          rd_beat;
    wire [1:0]    rd_index;
    wire [3:0]    rd_off    = rd_sel - 4'h3;
    wire [3:0]    wr_off    = wr_sel - 4'h7;
    wire          last_beat = ({30'h0, beat_q} == LAST_BEAT);

    // decode a byte address to a register number, 0 when unmapped
    function [3:0] reg_decode;
        input [AW-1:0] a;
        begin
            case (a)
                `SDBP_OFS_OP_CONTROL:   reg_decode = 4'h1;
                `SDBP_OFS_ADDR_COMMAND: reg_decode = 4'h2;
                `SDBP_OFS_READ_BEAT0:   reg_decode = 4'h3;
                `SDBP_OFS_READ_BEAT1:   reg_decode = 4'h4;
                `SDBP_OFS_READ_BEAT2:   reg_decode = 4'h5;
                `SDBP_OFS_READ_BEAT3:   reg_decode = 4'h6;
                `SDBP_OFS_WRITE_BEAT0:  reg_decode = 4'h7;
                `SDBP_OFS_WRITE_BEAT1:  reg_decode = 4'h8;
                `SDBP_OFS_WRITE_BEAT2:  reg_decode = 4'h9;
                `SDBP_OFS_WRITE_BEAT3:  reg_decode = 4'ha;
                `SDBP_OFS_BYTE_MASK:    reg_decode = 4'hb;
                default:                reg_decode = 4'h0;
            endcase
        end
    endfunction

    // merge enabled byte lanes of a write into a stored word
    function [DW-1:0] lane_merge;
        input [DW-1:0] old_w;
        input [DW-1:0] new_w;
        input [3:0]    be;
        integer        i;
        begin
            lane_merge = old_w;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (be[i])
                begin
                    lane_merge[i*8 +: 8] = new_w[i*8 +: 8];
                end
            end
        end
    endfunction

    assign wr_sel    = i_reg_wr ? reg_decode(i_reg_addr) : 4'h0;
    assign rd_sel    = i_reg_rd ? reg_decode(i_reg_addr) : 4'h0;
    // a start takes effect only when the port is idle and the lane holding bit 0..1 is enabled
    assign launch_wr = (wr_sel == 4'h1) && i_reg_be[0] && i_reg_wdata[`SDBP_CTL_START_WRITE] &&
                       (state_q == ST_IDLE); // [RL1]
    assign launch_rd = (wr_sel == 4'h1) && i_reg_be[0] && i_reg_wdata[`SDBP_CTL_START_READ] &&
                       !launch_wr && (state_q == ST_IDLE); // [RL2]
    assign cmd_taken = o_cmd_valid && i_cmd_ready;
    assign wdf_taken = o_wdf_valid && i_wdf_ready;
    assign rd_beat   = (state_q == ST_RWAIT) && i_rd_data_valid;
    assign rd_index  = (rd_sel >= 4'h3 && rd_sel <= 4'h6) ? rd_off[1:0] : 2'h0;

    // returned read beats land here in arrival order
    sdbp_beat_mem #(
        .W  (DW),
        .D  (BEATS),
        .AW (2)
    ) u_read_beats (
        .i_clk   (i_clk),
        .i_wen   (rd_beat),     // [RL14]
        .i_waddr (beat_q),
        .i_wdata (i_rd_data),
        .i_raddr (rd_index),
        .o_rdata (mem_rdata)
    );

    // software-visible registers
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            addr_cmd_q <= `SDBP_RST_WORD;
            mask_q     <= `SDBP_RST_WORD;
            wbeat_q[0] <= `SDBP_RST_WORD;
            wbeat_q[1] <= `SDBP_RST_WORD;
            wbeat_q[2] <= `SDBP_RST_WORD;
            wbeat_q[3] <= `SDBP_RST_WORD;
        end
        else
        begin
            if (wr_sel == 4'h2)
                addr_cmd_q <= lane_merge(addr_cmd_q, i_reg_wdata, i_reg_be) & `SDBP_AC_USED_MASK; // [RL5]
            if (wr_sel == 4'hb)
                mask_q <= lane_merge(mask_q, i_reg_wdata, i_reg_be) & `SDBP_MASK_USED; // [RL5]
            if (wr_sel >= 4'h7 && wr_sel <= 4'ha)
                wbeat_q[wr_off[1:0]] <= lane_merge(wbeat_q[wr_off[1:0]], i_reg_wdata, i_reg_be); // [RL18]
        end
    end

    // start bits: pending until the command is accepted
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            start_wr_q <= 1'b0;
            start_rd_q <= 1'b0;
        end
        else
        begin
            if (launch_wr)
                start_wr_q <= 1'b1; // [RL1]
            else if (cmd_taken)
                start_wr_q <= 1'b0; // [RL22]
            if (launch_rd)
                start_rd_q <= 1'b1; // [RL2]
            else if (cmd_taken)
                start_rd_q <= 1'b0; // [RL22]
        end
    end

    // burst sequencer
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (launch_wr)
                    state_d = ST_WDATA;
                else if (launch_rd)
                    state_d = ST_CMD;
            end
            ST_WDATA:
            begin
                if (wdf_taken && last_beat)
                    state_d = ST_CMD; // [RL15]
            end
            ST_CMD:
            begin
                if (cmd_taken)
                    state_d = start_rd_q ? ST_RWAIT : ST_IDLE;
            end
            ST_RWAIT:
            begin
                if (rd_beat && last_beat)
                    state_d = ST_IDLE; // [RL15]
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_q               <= ST_IDLE;
            beat_q                <= 2'h0;
            o_wdf_valid           <= 1'b0;
            o_wdf_data            <= `SDBP_RST_WORD;
            o_byte_write_suppress <= 4'h0;
            o_cmd_valid           <= 1'b0;
            o_cmd_code            <= 3'h0;
            o_bank_select_high    <= 1'b0;
            o_bank_select_low     <= 1'b0;
            o_cmd_row             <= 13'h0;
            o_cmd_col             <= 10'h0;
        end
        else
        begin
            state_q <= state_d;
            if (launch_wr)
            begin
                beat_q                <= 2'h0;
                o_wdf_valid           <= 1'b1;
                o_wdf_data            <= wbeat_q[0];       // [RL18]
                o_byte_write_suppress <= mask_q[3:0];      // [RL19] [RL20] [RL21]
            end
            else if (wdf_taken)
            begin
                beat_q <= beat_q + 2'h1;
                if (last_beat)
                begin
                    o_wdf_valid <= 1'b0;
                    beat_q      <= 2'h0;
                end
                else
                begin
                    o_wdf_data            <= wbeat_q[beat_q + 2'h1];          // [RL18]
                    o_byte_write_suppress <= mask_q[4*(beat_q + 2'h1) +: 4]; // [RL20]
                end
            end
            else if (rd_beat)
            begin
                beat_q <= beat_q + 2'h1; // [RL14]
            end
            // command pushed once the data beats are in, or right away for a read
            if ((state_q == ST_IDLE && launch_rd) || (state_q == ST_WDATA && state_d == ST_CMD))
            begin
                o_cmd_valid        <= 1'b1; // [RL22]
                o_cmd_code         <= addr_cmd_q[`SDBP_AC_CMD_MSB:`SDBP_AC_CMD_LSB];   // [RL9] [RL10]
                o_bank_select_high <= addr_cmd_q[`SDBP_AC_BANK_HIGH];                 // [RL8]
                o_bank_select_low  <= addr_cmd_q[`SDBP_AC_BANK_LOW];                  // [RL8]
                o_cmd_row          <= addr_cmd_q[`SDBP_AC_ROW_MSB:`SDBP_AC_ROW_LSB];   // [RL7]
                o_cmd_col          <= addr_cmd_q[`SDBP_AC_COL_MSB:`SDBP_AC_COL_LSB];   // [RL6]
                beat_q             <= 2'h0;
            end
            else if (cmd_taken)
            begin
                o_cmd_valid <= 1'b0; // [RL22]
            end
        end
    end

    // register reads: two edges from strobe to ack
    always @*
    begin
        rd_word_q = `SDBP_RST_WORD;
        case (rd_sel_q)
            4'h1:
            begin
                rd_word_q[`SDBP_CTL_START_WRITE]     = start_wr_q;
                rd_word_q[`SDBP_CTL_START_READ]      = start_rd_q;
                rd_word_q[`SDBP_CTL_WRITE_FIFO_NF]   = i_write_fifo_nearly_full;   // [RL3]
                rd_word_q[`SDBP_CTL_COMMAND_FIFO_NF] = i_command_fifo_nearly_full; // [RL4] [RL5]
            end
            4'h2:    rd_word_q = addr_cmd_q;
            4'h3, 4'h4, 4'h5, 4'h6:
                     rd_word_q = mem_rdata; // [RL14] [RL17]
            4'h7:    rd_word_q = wbeat_q[0];
            4'h8:    rd_word_q = wbeat_q[1];
            4'h9:    rd_word_q = wbeat_q[2];
            4'ha:    rd_word_q = wbeat_q[3];
            4'hb:    rd_word_q = mask_q;
            default: rd_word_q = `SDBP_RST_WORD;
        endcase
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            rd_pend_q    <= 1'b0;
            rd_sel_q     <= 4'h0;
            o_reg_rd_ack <= 1'b0;
            o_reg_rdata  <= `SDBP_RST_WORD;
        end
        else
        begin
            rd_pend_q    <= i_reg_rd;
            rd_sel_q     <= rd_sel;
            o_reg_rd_ack <= rd_pend_q;
            // full word returned; narrow reads take their lanes from it
            o_reg_rdata  <= rd_pend_q ? rd_word_q : `SDBP_RST_WORD; // [RL17]
        end
    end
endmodule

// file: sim/sdbp_port_asserts.sv
// concurrent checks on the ports of the sdram register burst port
`timescale 1ns/1ps
module sdbp_port_asserts #(
    parameter DW = 32,
    parameter AW = 16
) (
    input wire logic          i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_cmd_ready, i_wdf_ready,
    input wire logic          i_write_fifo_nearly_full, i_command_fifo_nearly_full,
    input wire logic [AW-1:0] i_reg_addr,
    input wire logic [DW-1:0] i_reg_wdata, o_reg_rdata, o_wdf_data,
    input wire logic          o_reg_rd_ack, o_cmd_valid, o_wdf_valid,
    input wire logic [2:0]    o_cmd_code,
    input wire logic          o_bank_select_high, o_bank_select_low,
    input wire logic [12:0]   o_cmd_row,
    input wire logic [9:0]    o_cmd_col
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [2:0]  beats_q;
    logic [31:0] ac_q;
    wire         ctl_wr = i_reg_wr && i_reg_addr == 16'h805c;
    // accepted write beats of the burst in flight
    always @(posedge i_clk)
    begin
        if (!i_rst_n || o_cmd_valid)
            beats_q <= 3'h0;
        else if (o_wdf_valid && i_wdf_ready)
            beats_q <= beats_q + 3'h1;
    end
    // shadow of the address/command register, bench always writes all lanes
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            ac_q <= 32'h0;
        else if (i_reg_wr && i_reg_addr == 16'h8060)
            ac_q <= i_reg_wdata & 32'he1ffffff;
    end
    a_read_latency: assert property (i_reg_rd |-> ##2 o_reg_rd_ack)
        else $error("read not answered two cycles after strobe");
    a_ack_cause: assert property (o_reg_rd_ack |-> $past(i_reg_rd, 2))
        else $error("read answer without a read strobe");
    a_flag_bits: assert property (o_reg_rd_ack && $past(i_reg_rd && i_reg_addr == 16'h805c, 2)
        |-> o_reg_rdata[27:26] == $past({i_command_fifo_nearly_full, i_write_fifo_nearly_full})
        && o_reg_rdata[25:2] == 24'h0 && o_reg_rdata[31:28] == 4'h0)
        else $error("control status bits wrong");
    a_write_launch: assert property ($rose(o_wdf_valid) |-> $past(ctl_wr && i_reg_wdata[0]))
        else $error("write burst without start");
    a_read_launch: assert property ($rose(o_cmd_valid) && o_cmd_code == 3'h1
        |-> $past(ctl_wr && i_reg_wdata[1] && !i_reg_wdata[0]))
        else $error("read command without read start");
    a_four_beats: assert property ($fell(o_wdf_valid) |-> beats_q == 3'h4 && o_cmd_valid)
        else $error("write burst not four beats then command");
    a_beat_hold: assert property (o_wdf_valid && !i_wdf_ready |=> o_wdf_valid && $stable(o_wdf_data))
        else $error("write beat dropped before accepted");
    a_cmd_hold: assert property (o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd_row))
        else $error("command dropped before accepted");
    a_cmd_once: assert property (o_cmd_valid && i_cmd_ready |=> !o_cmd_valid [*2])
        else $error("command pushed more than once");
    a_cmd_fields: assert property (o_cmd_valid |-> {o_cmd_code, o_bank_select_high, o_bank_select_low,
        o_cmd_row, o_cmd_col} == {ac_q[31:29], ac_q[24:0]})
        else $error("command fields differ from address register");
endmodule

bind sdbp_port sdbp_port_asserts #(.DW(DW), .AW(AW)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_cmd_ready(i_cmd_ready), .i_wdf_ready(i_wdf_ready), .i_reg_addr(i_reg_addr),
    .i_write_fifo_nearly_full(i_write_fifo_nearly_full), .i_command_fifo_nearly_full(i_command_fifo_nearly_full),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_wdf_data(o_wdf_data),
    .o_reg_rd_ack(o_reg_rd_ack), .o_cmd_valid(o_cmd_valid), .o_wdf_valid(o_wdf_valid),
    .o_cmd_code(o_cmd_code), .o_bank_select_high(o_bank_select_high),
    .o_bank_select_low(o_bank_select_low), .o_cmd_row(o_cmd_row), .o_cmd_col(o_cmd_col)
);

// file: sim/sdbp_ctrl_model.sv
// behavioural memory controller and sdram behind the burst port
`timescale 1ns/1ps
module sdbp_ctrl_model (
    input  wire logic        i_clk, i_rst_n, i_cmd_valid, i_wdf_valid, i_bsh, i_bsl, i_slow,
    input  wire logic [2:0]  i_code,
    input  wire logic [12:0] i_row,
    input  wire logic [9:0]  i_col,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_keep,
    output logic             o_cmd_ready, o_wdf_ready, o_rd_valid,
    output logic [31:0]      o_rd_data
);
    logic [31:0] mem [int];
    logic [31:0] wq [$];
    logic [3:0]  kq [$];
    logic [31:0] w;
    int          base, pend, k, b;
    always @(posedge i_clk)
    begin
        o_cmd_ready <= !i_slow || ($urandom % 3 == 0);
        o_wdf_ready <= !i_slow || ($urandom % 2 == 0);
        o_rd_valid <= 1'b0;
        // read bus inverts its word every cycle between beats
        o_rd_data <= ~o_rd_data;
        if (!i_rst_n)
        begin
            pend = 0;
            o_rd_data <= 32'h0;
        end
        if (i_wdf_valid && o_wdf_ready)
        begin
            wq.push_back(i_wdata);
            kq.push_back(i_keep);
        end
        if (i_cmd_valid && o_cmd_ready)
        begin
            base = {i_bsh, i_bsl, i_row, i_col};
            pend = (i_code == 3'h1) ? 4 : 0;
            for (k = 0; k < 4 && i_code == 3'h0 && wq.size() > 0; k++)
            begin
                w = mem.exists(base + k) ? mem[base + k] : 32'h0;
                for (b = 0; b < 4; b++)
                    if (!kq[0][b])
                        w[8*b +: 8] = wq[0][8*b +: 8];
                mem[base + k] = w;
                void'(wq.pop_front());
                void'(kq.pop_front());
            end
        end
        else if (pend > 0 && (!i_slow || $urandom % 2 == 0))
        begin
            o_rd_valid <= 1'b1;
            o_rd_data <= mem.exists(base + 4 - pend) ? mem[base + 4 - pend] : 32'h0;
            pend = pend - 1;
        end
    end
endmodule

// file: sim/test_sdram_register_burst_port.sv
// self-checking bench of the sdram register burst port
`timescale 1ns/1ps
module test_sdram_register_burst_port;
    logic        i_clk, i_rst_n, i_reg_wr, i_reg_rd, slow, wf_nf, cf_nf;
    logic [3:0]  be;
    logic [15:0] i_reg_addr;
    logic [31:0] i_reg_wdata, v;
    logic [31:0] wd [4];
    logic [31:0] last [4];
    logic [31:0] exp_mem [int];
    wire  [31:0] o_reg_rdata, o_wdf_data, rd_data;
    wire  [12:0] row;
    wire  [9:0]  col;
    wire  [3:0]  keep;
    wire  [2:0]  code;
    wire         o_reg_rd_ack, cmd_valid, cmd_ready, wdf_valid, wdf_ready, rd_valid, bsh, bsl;
    int          err_count, total_checks, cyc, k, nb;

    sdbp_port dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_be(be), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rd_ack(o_reg_rd_ack),
        .o_cmd_valid(cmd_valid), .i_cmd_ready(cmd_ready), .o_cmd_code(code), .o_bank_select_high(bsh),
        .o_bank_select_low(bsl), .o_cmd_row(row), .o_cmd_col(col), .o_wdf_valid(wdf_valid),
        .i_wdf_ready(wdf_ready), .o_wdf_data(o_wdf_data), .o_byte_write_suppress(keep),
        .i_rd_data_valid(rd_valid), .i_rd_data(rd_data), .i_write_fifo_nearly_full(wf_nf),
        .i_command_fifo_nearly_full(cf_nf)
    );
    sdbp_ctrl_model u_ctrl (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid), .i_wdf_valid(wdf_valid), .i_bsh(bsh),
        .i_bsl(bsl), .i_slow(slow), .i_code(code), .i_row(row), .i_col(col), .i_wdata(o_wdf_data),
        .i_keep(keep), .o_cmd_ready(cmd_ready), .o_wdf_ready(wdf_ready), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data)
    );

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
        for (int b = 0; b < 4; b++)
            if (!m[b])
                o[8*b +: 8] = n[8*b +: 8];
        return o;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // all register tasks start and end just after a falling edge
    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
        // one idle edge so a following write never re-raises the strobe in the same step
        @(negedge i_clk);
    endtask
    task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        for (int n = 0; n < 4 && o_reg_rd_ack !== 1'b1; n++)
            @(negedge i_clk);
        d = (o_reg_rd_ack === 1'b1) ? o_reg_rdata : 32'hx;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] want);
        reg_rd(a, v);
        check(v, want);
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 60; n++)
        begin
            reg_rd(16'h805c, v);
            if (v[1:0] === 2'h0)
                break;
        end
        check(v & 32'h3, 32'h0);
    endtask
    task automatic burst(input logic [15:0] msk);
        logic [31:0] ac;
        ac = {7'h0, 2'($urandom), ($urandom % 2) ? 13'h1fff : 13'h0, ($urandom % 2) ? 10'h3fc : 10'h0};
        for (k = 0; k < 4; k++)
        begin
            wd[k] = $urandom;
            reg_wr(16'h8074 + 16'(4 * k), wd[k]);
            rd_chk(16'h8074 + 16'(4 * k), wd[k]);
        end
        reg_wr(16'h8084, {16'h0, msk});
        reg_wr(16'h8060, ac);
        reg_wr(16'h805c, 32'h1);
        wait_idle();
        for (k = 0; k < 4; k++)
        begin
            exp_mem[ac + k] = merge(exp_mem.exists(ac + k) ? exp_mem[ac + k] : 32'h0, wd[k], msk[4*k +: 4]);
            if (nb > 0)
                rd_chk(16'h8064 + 16'(4 * k), last[k]);
        end
        reg_wr(16'h8060, ac | 32'h20000000);
        reg_wr(16'h805c, 32'h2);
        // settling time before fetching, 100 cycles of 5 ns
        repeat (100) @(negedge i_clk);
        wait_idle();
        for (k = 0; k < 4; k++)
        begin
            last[k] = exp_mem[ac + k];
            rd_chk(16'h8064 + 16'(4 * k), last[k]);
        end
        nb++;
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    initial
    begin
        i_rst_n = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 16'h0;
        i_reg_wdata = 32'h0;
        slow = 1'b0;
        be = 4'hf;
        wf_nf = 1'b0;
        cf_nf = 1'b0;
        void'($urandom(18135));
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
        for (k = 'h805c; k <= 'h8084; k += 4)
            if (k < 'h8064 || k > 'h8070)
                rd_chk(16'(k), 32'h0);
        rd_chk(16'h8088, 32'h0);
        reg_wr(16'h8060, 32'hffffffff);
        rd_chk(16'h8060, 32'he1ffffff);
        reg_wr(16'h8084, 32'hffffffff);
        rd_chk(16'h8084, 32'h0000ffff);
        // single-lane write merges into the stored mask
        be = 4'h1;
        reg_wr(16'h8084, 32'h12345678);
        be = 4'hf;
        rd_chk(16'h8084, 32'h0000ff78);
        reg_wr(16'h805c, 32'hfffffffc);
        rd_chk(16'h805c, 32'h0);
        for (k = 0; k < 4; k++)
        begin
            {cf_nf, wf_nf} = 2'(k);
            rd_chk(16'h805c, {4'h0, 2'(k), 26'h0});
        end
        {cf_nf, wf_nf} = 2'h0;
        burst(16'h0);
        burst(16'hffff);
        repeat (8)
        begin
            slow = 1'($urandom);
            burst(16'($urandom));
        end
        report_and_stop();
    end
endmodule
